/* common/trip_pkg.sv */
package trip_pkg;

  // ------------------------------------------------------------
  // clocking and timebases
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int PCM_MHZ = 8;
  localparam int STRETCH_TICK_MS = 1;
  localparam int TICK_CYC_DEFAULT = STRETCH_TICK_MS * 1000 * CLK_MHZ;
  localparam logic [4:0] PCM_STEP = 5'(PCM_MHZ);
  localparam logic [4:0] PCM_WRAP = 5'(CLK_MHZ);

  // ------------------------------------------------------------
  // trip configuration field of device_config_reg
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AVG = 2'h1;
  localparam logic [1:0] MODE_COUNT = 2'h2;
  localparam logic [1:0] MODE_UNFILT = 2'h3;
  localparam logic [2:0] CFG_PCM = 3'h4;
  localparam int POL_BIT = 2;

  // ------------------------------------------------------------
  // serial command and response layout
  // ------------------------------------------------------------
  localparam logic [4:0] CMD_LEN = 5'h10;
  localparam int CMD_REG_BIT = 15;
  localparam int CMD_AXIS_BIT = 14;
  localparam int CMD_ACC_BIT = 13;
  localparam logic [3:0] RESP_TAG = 4'h1;

  // ------------------------------------------------------------
  // stretch lengths in timebase ticks, per stretch_select
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [7:0] STRETCH_SHORT = 8'h14;
  localparam logic [7:0] STRETCH_MID = 8'h50;
  localparam logic [7:0] STRETCH_LONG = 8'hf0;

  // ------------------------------------------------------------
  // sample processing
  // ------------------------------------------------------------
  localparam int HIST_DEPTH = 8;
  localparam logic signed [11:0] SAT_MAX = 12'sh0ff;
  localparam logic signed [11:0] SAT_MIN = 12'shf00;
  localparam logic [8:0] PCM_BIAS = 9'h100;
  localparam logic [3:0] HITS_MAX = 4'hf;

endpackage

/* design/trip_out.sv */
`timescale 1ns/1ps

// Behaviour
// - unfiltered: at request end compare newest sample to both thresholds
// - unfiltered: trip pin active while selected and answer carries acceleration
// - no stretching while in unfiltered mode
// - stretching only in averaging or count mode
// - select 00: pin follows latest evaluated trip condition
// - select nonzero: pin active exactly while stretch timer nonzero
// - stretch timer counts down on its timebase, holds at zero
// - stretch timer reloads only when latest evaluation trips
// - stretch length comes from two-bit stretch_select field
// - during exception, running stretch finishes, new reads never reload
// - trip pin polarity chosen by configuration field
// - pulse-density selection turns shared pin into that stream
// - sample saturated to nine bits, offset to unsigned 0..511
// - nine-bit value summed at 8 MHz, carry drives pin
// - serial slave: clock idles low, sample first edge, msb first
// - transfer in two phases: command first, data in later transfer
// - serial clock and data ignored while select negated
// - averaging mode: mean reaching threshold trips and loads stretch
// - count mode: consecutive hits counted, limit reached trips
module trip_out import trip_pkg::*; #(
  parameter int TICK_CYC = TICK_CYC_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // sample path, same clock
  input wire logic [11:0] oc_sample,
  input wire logic exception_in,
  // configuration bits
  input wire logic [2:0] trip_cfg,
  input wire logic [1:0] stretch_select,
  input wire logic [1:0] window_size_field,
  input wire logic [7:0] thr_pos,
  input wire logic [7:0] thr_neg,
  // shared trip / pulse-density pin
  output logic arm_pin
);

  typedef struct packed {
    logic [2:0] cs_r;
    logic [2:0] sck_r;
    logic [1:0] mosi_r;
    logic [15:0] rx_r;
    logic [15:0] tx_r;
    logic [4:0] nbits_r;
    logic resp_pend_r;
    logic resp_acc_r;
    logic [11:0] resp_data_r;
    logic [HIST_DEPTH-1:0][11:0] hist_r;
    logic [3:0] hits_r;
    logic cond_r;
    logic [7:0] stretch_r;
    logic [14:0] tick_r;
    logic [4:0] frac_r;
    logic [8:0] acc_r;
    logic pcm_r;
    logic miso_r;
    logic arm_pin_r;
  } st_s;

  st_s st_r;
  st_s st_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // thresholds act on the top eight bits of the sample
  function automatic logic trip_hit(input logic [11:0] v, input logic [7:0] p,
                                    input logic [7:0] n);
    logic signed [8:0] hi;
    hi = $signed({v[11], v[11:4]});
    return (hi >= $signed({1'b0, p})) || (hi <= -$signed({1'b0, n}));
  endfunction

  // mean of the newest 2^w samples; a power of two keeps it a shift
  function automatic logic [11:0] mean_of(input logic [HIST_DEPTH-1:0][11:0] h,
                                          input logic [1:0] w);
    logic signed [14:0] s;
    s = '0;
    for (int i = 0; i < HIST_DEPTH; i++) begin
      if (i < (1 << w)) begin
        s = s + 15'($signed(h[i]));
      end
    end
    return 12'(s >>> w);
  endfunction

  // ------------------------------------------------------------
  // decoded events
  // ------------------------------------------------------------
  logic cs_act, cs_fall, cs_rise, sck_rise, sck_fall, eval, upd, tick, pcm_tick;
  logic cond_new, load;
  logic [1:0] mode;
  logic [HIST_DEPTH-1:0][11:0] hist_new;
  logic [3:0] hits_new;
  logic [7:0] stretch_val;
  logic [8:0] pcm_val;
  logic [5:0] frac_sum;
  logic [9:0] acc_sum;

  // only the second and third sync stages are looked at
  assign cs_act = ~st_r.cs_r[1];
  assign cs_fall = st_r.cs_r[2] & ~st_r.cs_r[1];
  assign cs_rise = ~st_r.cs_r[2] & st_r.cs_r[1];
  assign sck_rise = cs_act & ~st_r.sck_r[2] & st_r.sck_r[1];
  assign sck_fall = cs_act & st_r.sck_r[2] & ~st_r.sck_r[1];
  assign mode = trip_cfg[1:0];
  assign eval = cs_rise && (st_r.nbits_r == CMD_LEN) && !st_r.rx_r[CMD_REG_BIT]
                && !st_r.rx_r[CMD_AXIS_BIT] && st_r.rx_r[CMD_ACC_BIT];
  assign upd = eval && !exception_in && (mode != MODE_OFF);
  assign tick = (st_r.tick_r == 15'(TICK_CYC - 1));
  assign hist_new = {st_r.hist_r[HIST_DEPTH-2:0], oc_sample};
  assign hits_new = !trip_hit(oc_sample, thr_pos, thr_neg) ? 4'h0 :
                    (st_r.hits_r == HITS_MAX) ? HITS_MAX : st_r.hits_r + 4'h1;

  always_comb begin
    unique case (mode)
      MODE_AVG: cond_new = trip_hit(mean_of(hist_new, window_size_field), thr_pos, thr_neg);
      MODE_COUNT: cond_new = hits_new >= (4'h1 << window_size_field);
      MODE_UNFILT: cond_new = trip_hit(oc_sample, thr_pos, thr_neg);
      MODE_OFF: cond_new = 1'b0;
    endcase
  end

  always_comb begin
    unique case (stretch_select)
      2'h1: stretch_val = STRETCH_SHORT;
      2'h2: stretch_val = STRETCH_MID;
      2'h3: stretch_val = STRETCH_LONG;
      SEL_NONE: stretch_val = 8'h00;
    endcase
  end

  // load only on trip in filtered modes
  assign load = upd && cond_new && (stretch_select != SEL_NONE)
                && ((mode == MODE_AVG) || (mode == MODE_COUNT));

  assign pcm_val = ($signed(oc_sample) > SAT_MAX) ? (SAT_MAX[8:0] + PCM_BIAS) :
                   ($signed(oc_sample) < SAT_MIN) ? (SAT_MIN[8:0] + PCM_BIAS) :
                   (oc_sample[8:0] + PCM_BIAS);
  // 8 MHz strobe from a fractional step of 8/25
  assign frac_sum = {1'b0, st_r.frac_r} + {1'b0, PCM_STEP};
  assign pcm_tick = frac_sum >= {1'b0, PCM_WRAP};
  assign acc_sum = {1'b0, st_r.acc_r} + {1'b0, pcm_val};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_r = {st_r.cs_r[1:0], cs_n};
    st_nxt.sck_r = {st_r.sck_r[1:0], sclk};
    st_nxt.mosi_r = {st_r.mosi_r[0], mosi};
    // shifter, mode 0, msb first, idle while deselected
    if (cs_fall) begin
      st_nxt.nbits_r = 5'h0;
      st_nxt.resp_acc_r = st_r.resp_pend_r;
      st_nxt.tx_r = st_r.resp_pend_r ? {RESP_TAG, st_r.resp_data_r} : 16'h0000;
      st_nxt.miso_r = st_r.resp_pend_r & RESP_TAG[3];
    end else if (sck_rise) begin
      st_nxt.rx_r = {st_r.rx_r[14:0], st_r.mosi_r[1]};
      st_nxt.nbits_r = (st_r.nbits_r == CMD_LEN) ? CMD_LEN : st_r.nbits_r + 5'h1;
    end else if (sck_fall) begin
      st_nxt.tx_r = {st_r.tx_r[14:0], 1'b0};
      st_nxt.miso_r = st_r.tx_r[14];
    end
    // data latched now, returned next transfer
    if (cs_rise) begin
      st_nxt.resp_acc_r = 1'b0;
      st_nxt.resp_pend_r = eval;
      st_nxt.miso_r = 1'b0;
      if (eval) begin
        st_nxt.resp_data_r = oc_sample;
      end
    end
    if (upd) begin
      st_nxt.hist_r = hist_new;
      st_nxt.hits_r = hits_new;
      st_nxt.cond_r = cond_new;
    end
    st_nxt.tick_r = tick ? 15'h0 : st_r.tick_r + 15'h1;
    if (load) begin
      st_nxt.stretch_r = stretch_val;
    end else if (tick && (st_r.stretch_r != 8'h00)) begin
      st_nxt.stretch_r = st_r.stretch_r - 8'h01;
    end
    // nine-bit wrapping accumulator at 8 MHz
    st_nxt.frac_r = pcm_tick ? 5'(frac_sum - {1'b0, PCM_WRAP}) : frac_sum[4:0];
    if (pcm_tick) begin
      st_nxt.acc_r = acc_sum[8:0];
      st_nxt.pcm_r = acc_sum[9];
    end
    if (trip_cfg == CFG_PCM) begin
      st_nxt.arm_pin_r = st_r.pcm_r;
    end else begin
      unique case (mode)
        MODE_UNFILT: st_nxt.arm_pin_r = st_r.cond_r & cs_act & st_r.resp_acc_r;
        MODE_AVG, MODE_COUNT: st_nxt.arm_pin_r = (stretch_select == SEL_NONE) ?
                                  st_r.cond_r : (st_r.stretch_r != 8'h00);
        MODE_OFF: st_nxt.arm_pin_r = 1'b0;
      endcase
      st_nxt.arm_pin_r = st_nxt.arm_pin_r ^ trip_cfg[POL_BIT];
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // everything inactive from reset; a low-polarity pin settles next edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.cs_r <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign miso = st_r.miso_r;
  assign arm_pin = st_r.arm_pin_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_unfilt_hold;
    @(posedge clk) disable iff (!resetn)
      (mode == MODE_UNFILT && st_r.stretch_r == 8'h00) |=> st_r.stretch_r == 8'h00;
  endproperty
  a_unfilt_hold: assert property (p_unfilt_hold) else $error("stretch loaded in unfiltered");

  property p_reload;
    @(posedge clk) disable iff (!resetn)
      (upd && cond_new && mode == MODE_COUNT && stretch_select == 2'h2)
      |=> st_r.stretch_r == STRETCH_MID;
  endproperty
  a_reload: assert property (p_reload) else $error("stretch not reloaded");

  property p_no_load;
    @(posedge clk) disable iff (!resetn)
      (!eval && st_r.stretch_r != 8'h00) |=> st_r.stretch_r <= $past(st_r.stretch_r);
  endproperty
  a_no_load: assert property (p_no_load) else $error("stretch rose without trip");

  property p_count_down;
    @(posedge clk) disable iff (!resetn)
      (tick && !load && st_r.stretch_r != 8'h00) |=> st_r.stretch_r == $past(st_r.stretch_r) - 8'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("stretch did not decrement");

  property p_hold_zero;
    @(posedge clk) disable iff (!resetn)
      (st_r.stretch_r == 8'h00 && !load) |=> st_r.stretch_r == 8'h00;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("stretch left zero");

  property p_exc_freeze;
    @(posedge clk) disable iff (!resetn)
      (eval && exception_in) |=> ($stable(st_r.cond_r) && st_r.stretch_r <= $past(st_r.stretch_r));
  endproperty
  a_exc_freeze: assert property (p_exc_freeze) else $error("exception read updated trip");

  property p_follow;
    @(posedge clk) disable iff (!resetn)
      (mode == MODE_AVG && stretch_select == SEL_NONE && !trip_cfg[POL_BIT])
      |=> arm_pin == $past(st_r.cond_r);
  endproperty
  a_follow: assert property (p_follow) else $error("pin not following trip");

  property p_stretch_pin;
    @(posedge clk) disable iff (!resetn)
      (mode == MODE_COUNT && stretch_select != SEL_NONE && trip_cfg[POL_BIT])
      |=> arm_pin == ($past(st_r.stretch_r) == 8'h00);
  endproperty
  a_stretch_pin: assert property (p_stretch_pin) else $error("pin not tied to timer");

  property p_unfilt_gate;
    @(posedge clk) disable iff (!resetn)
      (mode == MODE_UNFILT && !trip_cfg[POL_BIT] && !cs_act) |=> !arm_pin;
  endproperty
  a_unfilt_gate: assert property (p_unfilt_gate) else $error("pin active while deselected");

  property p_sat;
    @(posedge clk) disable iff (!resetn)
      ($signed(oc_sample) > SAT_MAX) |-> pcm_val == 9'h1ff;
  endproperty
  a_sat: assert property (p_sat) else $error("pulse-density value not saturated");

  property p_accum;
    @(posedge clk) disable iff (!resetn)
      pcm_tick |=> st_r.acc_r == 9'($past(st_r.acc_r) + $past(pcm_val));
  endproperty
  a_accum: assert property (p_accum) else $error("accumulator step wrong");

  property p_pcm_pin;
    @(posedge clk) disable iff (!resetn)
      (trip_cfg == CFG_PCM) |=> arm_pin == $past(st_r.pcm_r);
  endproperty
  a_pcm_pin: assert property (p_pcm_pin) else $error("pin not carrying carry stream");

  c_trip_avg: cover property (@(posedge clk) disable iff (!resetn) upd && mode == MODE_AVG && cond_new);
  c_expire: cover property (@(posedge clk) disable iff (!resetn)
    st_r.stretch_r == 8'h01 && tick ##1 st_r.stretch_r == 8'h00);
  c_carry: cover property (@(posedge clk) disable iff (!resetn) pcm_tick && acc_sum[9]);
  c_unfilt_on: cover property (@(posedge clk) disable iff (!resetn)
    mode == MODE_UNFILT && st_r.cond_r && st_r.resp_acc_r && cs_act);

endmodule

/* dv/spi_master_model.sv */
`timescale 1ns/1ps
// --------
// serial master partner
// --------
module spi_master_model (
  // clock
  input wire logic clk,
  // wiggle sclk while deselected
  input wire logic noise,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  logic busy = 1'b0;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // other slaves
  // data flips between frames so a stale bit never looks valid
  always @(posedge clk) begin
    if (!busy) begin
      mosi <= ~mosi;
      if (noise) sclk <= ~sclk;
      else sclk <= 1'b0;
    end
  end
  // mode 0 frame
  // half period of 4 clk keeps the 320 ns link rate
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    busy = 1'b1;
    @(posedge clk) sclk <= 1'b0;
    @(posedge clk) cs_n <= 1'b0;
    mosi <= cmd[15];
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      rsp[i] = miso;
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      if (i > 0) mosi <= cmd[i-1];
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    @(posedge clk) busy = 1'b0;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
// --------
// bench top
// --------
module tb_top import trip_pkg::*; ;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic exception_in = 1'b0;
  logic noise = 1'b0;
  logic cs_n, sclk, mosi, miso, arm_pin;
  logic [11:0] oc_sample = 12'h000;
  logic [2:0] trip_cfg = 3'h0;
  logic [1:0] stretch_select = 2'h0;
  logic [1:0] window_size_field = 2'h0;
  logic [7:0] thr_pos = 8'h10;
  logic [7:0] thr_neg = 8'h10;
  logic [11:0] last_s = 12'h000;
  logic last_req = 1'b0;
  // newest accepted sample first, never more than the history depth
  logic [11:0] hq[$];
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 50;
  int hits = 0;
  int clk_n = 0;
  int t0;
  int h[3];
  logic [11:0] smp[8] = '{12'h100, 12'h0ff, 12'hf00, 12'hf10, 12'h7f0, 12'h800, 12'h000,
    12'h050};

  // 25 MHz clock, free cycle count for spans
  always #20 clk = ~clk;
  always @(posedge clk) clk_n <= clk_n + 1;

  spi_master_model master (.clk(clk), .noise(noise), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso));
  // short timebase so the longest stretch stays under a thousand cycles
  trip_out #(.TICK_CYC(TK)) u_trip_out (.clk(clk), .resetn(resetn), .cs_n(cs_n),
    .sclk(sclk), .mosi(mosi), .miso(miso), .oc_sample(oc_sample),
    .exception_in(exception_in), .trip_cfg(trip_cfg), .stretch_select(stretch_select),
    .window_size_field(window_size_field), .thr_pos(thr_pos), .thr_neg(thr_neg),
    .arm_pin(arm_pin));

  // --------
  // reporting
  // --------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_span(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // --------
  // model
  // --------
  function automatic logic trips(input logic [11:0] s);
    int v;
    v = $signed(s[11:4]);
    return v >= int'(thr_pos) || v <= -int'(thr_neg);
  endfunction
  function automatic int slen(input logic [1:0] sel);
    return sel == 2'h1 ? STRETCH_SHORT : sel == 2'h2 ? STRETCH_MID : STRETCH_LONG;
  endfunction
  // one frame; mid >= 0 samples the pin inside the frame
  task automatic frame(input logic [15:0] cmd, input int mid);
    logic [15:0] rsp;
    logic [15:0] exp;
    exp = last_req ? {RESP_TAG, last_s} : 16'h0000;
    fork
      master.xfer(cmd, rsp);
      if (mid >= 0) begin
        repeat (60) @(negedge clk);
        chk_bit(arm_pin, mid[0]);
      end
    join
    chk_word(rsp, exp);
    last_req = cmd[15:13] === 3'b001;
    last_s = oc_sample;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic req(input logic [11:0] s, input int mid);
    logic c;
    int sum;
    logic [11:0] m;
    @(posedge clk) oc_sample <= s;
    frame(16'h2000, mid);
    // history and hit count move only on reads that are accepted
    if (!exception_in && trip_cfg[1:0] != MODE_OFF) begin
      hits = trips(s) ? hits + 1 : 0;
      hq.push_front(s);
      if (hq.size() > HIST_DEPTH) void'(hq.pop_back());
    end
    // mean of the newest 2^w samples, floor division like a shift
    sum = 0;
    for (int i = 0; i < (1 << window_size_field) && i < hq.size(); i++) begin
      sum += $signed(hq[i]);
    end
    m = 12'(sum >>> window_size_field);
    c = trip_cfg[1:0] == MODE_COUNT ? hits >= (1 << window_size_field) :
        trip_cfg[1:0] == MODE_AVG ? trips(m) : trips(s);
    if (trip_cfg[1:0] != MODE_UNFILT && stretch_select == SEL_NONE)
      chk_bit(arm_pin, c ^ trip_cfg[2]);
  endtask
  task automatic setup(input logic [2:0] cfg, input logic [1:0] sel, input logic [1:0] w);
    @(posedge clk) trip_cfg <= 3'h0;
    @(posedge clk) {stretch_select, window_size_field} <= {sel, w};
    @(posedge clk) trip_cfg <= cfg;
  endtask
  // bounded wait for the pin to go inactive, then judge the span
  task automatic span(input int from, input int len);
    int n;
    for (n = 0; n < 4000 && (arm_pin ^ trip_cfg[POL_BIT]) === 1'b1; n++) @(negedge clk);
    if (n == 4000) begin
      n_errors++;
      give_verdict;
    end else begin
      chk_span(clk_n - from, len - 16, len + 4);
    end
  endtask

  // --------
  // scenarios
  // --------
  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk_bit(arm_pin, 1'b0);
    chk_bit(miso, 1'b0);
    @(posedge clk) resetn <= 1'b1;
    repeat (4) @(posedge clk);
    $display("test reset done");
    noise <= 1'b1;
    setup(3'h1, 2'h0, 2'h0);
    foreach (smp[i]) req(smp[i], -1);
    for (int i = 0; i < 4; i++) req(12'($random(seed)), -1);
    // wider averaging windows, each change made with the function off
    for (int w = 1; w < 4; w++) begin
      setup(3'h1, 2'h0, w[1:0]);
      foreach (smp[i]) req(smp[i], -1);
    end
    frame(16'h8000, -1);
    frame(16'h6000, -1);
    req(12'h000, -1);
    @(posedge clk) noise <= 1'b0;
    $display("test threshold done");
    setup(3'h5, 2'h0, 2'h0);
    req(12'h100, -1);
    req(12'h000, -1);
    $display("test polarity done");
    setup(3'h2, 2'h0, 2'h1);
    for (int i = 0; i < 5; i++) req(i == 1 || i == 2 || i == 4 ? 12'h100 : 12'h000, -1);
    $display("test count done");
    for (int sel = 1; sel < 4; sel++) begin
      setup(3'h1, sel[1:0], 2'h0);
      req(12'h100, -1);
      chk_bit(arm_pin, 1'b1);
      span(clk_n, slen(sel[1:0]) * TK);
    end
    // a miss and an exception hit must not reload the timer; pin active low here
    setup(3'h6, 2'h2, 2'h0);
    req(12'h100, -1);
    t0 = clk_n;
    req(12'h000, -1);
    chk_bit(arm_pin, 1'b0);
    @(posedge clk) exception_in <= 1'b1;
    req(12'h100, -1);
    @(posedge clk) exception_in <= 1'b0;
    span(t0, slen(2'h2) * TK);
    $display("test stretch done");
    setup(3'h3, 2'h3, 2'h0);
    req(12'h100, -1);
    chk_bit(arm_pin, 1'b0);
    req(12'h000, 1);
    chk_bit(arm_pin, 1'b0);
    req(12'h000, 0);
    $display("test unfiltered done");
    // pin duty is judged as a ratio, so pulse shape does not matter
    setup(3'h4, 2'h0, 2'h0);
    foreach (h[k]) begin
      @(posedge clk) oc_sample <= k == 0 ? 12'h800 : k == 1 ? 12'h7ff : 12'h000;
      repeat (100) @(posedge clk);
      h[k] = 0;
      // an unknown pin counts as high so it can never look like a clean zero
      repeat (3200) @(negedge clk) h[k] += arm_pin !== 1'b0;
    end
    chk_span(h[0], 0, 0);
    chk_span(h[1], 3100, 3200);
    chk_span(2 * h[2], h[1] - h[1] / 16, h[1] + h[1] / 16);
    $display("test pulse density done");
    give_verdict;
  end
endmodule
